/* File: pkg/sensor_readout_cfg.svh */
/*
  Constants of the sensor readout and programming-lock block: register
  addresses, frame layout, reset values and link timing.
  Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef SENSOR_READOUT_CFG_SVH
`define SENSOR_READOUT_CFG_SVH

`define CLK_PERIOD_NS 10
`define BIT_TIME_NS 1000
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define FRAME_BITS 24
`define RESP_BITS 19

`define ADDR_TEMP 5'h00
`define ADDR_RAW 5'h01
`define ADDR_FACTORY 5'h02
`define ADDR_CUSTOMER 5'h03
`define ADDR_COEF_BASE 5'h04
`define ADDR_COEF_LAST 5'h08
`define ADDR_SETUP 5'h09
`define ADDR_LOCK 5'h0a
`define ADDR_SETPT_BASE 5'h10

`define COEF_RESET 16'h0000
`define SETPT_RESET 16'h0000
`define SETUP_RESET 3'h1
`define NUM_COEFS 5
`define NUM_SETPTS 16
`define SAMPLE_W 22
`define SHIFT_TOP 3'h7

`endif

/* File: pkg/sensor_readout_pkg.sv */
/*
  Types of the sensor readout block: command codes, link states and the
  packed carriers for frames, measurements and coefficients.
  Assumes nothing of its surroundings.
*/
package sensor_readout_pkg;

  typedef enum logic [1:0] {
    CMD_NOP = 2'h0,
    CMD_READ = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_LOCK = 2'h3
  } cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_START = 6'b000010,
    ST_RX = 6'b000100,
    ST_EXEC = 6'b001000,
    ST_TX = 6'b010000,
    ST_GAP = 6'b100000
  } link_state_t;

  typedef struct packed {
    cmd_t cmd;
    logic die;
    logic [4:0] addr;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] raw;
    logic [15:0] factory;
    logic [15:0] customer;
  } meas_t;

  typedef struct packed {
    logic [15:0] ofs0;
    logic [15:0] ofs1;
    logic [15:0] g0;
    logic [15:0] g1;
    logic [15:0] g2;
  } coeff_t;

endpackage : sensor_readout_pkg

/* File: hw/field_path.sv */
/*
  Measurement path of one die: range shift with clamping, factory trim and
  customer temperature trim, captured into read-only registers.
  Assumes sample_valid_i is a one-cycle strobe in the mclk_i domain.
*/
`timescale 1ns/1ns
`include "sensor_readout_cfg.svh"

module field_path #(
  parameter logic signed [15:0] TEMP_TRIM = 16'sh0000,
  parameter logic signed [15:0] FACT_GAIN = 16'sh0000,
  parameter logic signed [15:0] FACT_OFS = 16'sh0000
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sample_valid_i,
  input wire logic [`SAMPLE_W-1:0] field_sample_i,
  input wire logic [15:0] temp_sample_i,
  input wire logic [2:0] barrel_i,
  input wire sensor_readout_pkg::coeff_t coeff_i,
  output sensor_readout_pkg::meas_t meas_o
);
  import sensor_readout_pkg::*;

  function automatic logic signed [47:0] sx16(input logic [15:0] v);
    sx16 = {{32{v[15]}}, v};
  endfunction : sx16

  // Clamp to the 16-bit signed range instead of wrapping
  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7fff) sat16 = 16'h7fff;
    else if (v < -48'sh8000) sat16 = 16'h8000;
    else sat16 = v[15:0];
  endfunction : sat16

  wire logic [2:0] shift = `SHIFT_TOP - barrel_i;
  wire logic signed [47:0] field_s = {{(48 - `SAMPLE_W){field_sample_i[`SAMPLE_W-1]}}, field_sample_i};
  wire logic signed [47:0] shifted = field_s >>> shift;
  wire logic [15:0] raw_d = sat16(shifted);
  wire logic [15:0] temp_d = sat16(sx16(temp_sample_i) + sx16(TEMP_TRIM));

  wire logic signed [47:0] raw_w = sx16(raw_d);
  wire logic [15:0] fact_d = sat16(raw_w + ((raw_w * sx16(FACT_GAIN)) >>> 15) + sx16(FACT_OFS));

  // Gain in Q15: one plus constant, linear and square terms of temperature
  wire logic signed [47:0] t_w = sx16(temp_d);
  wire logic signed [47:0] tt_w = t_w * t_w;
  wire logic signed [47:0] gain_w = 48'sh8000 + sx16(coeff_i.g0) + ((sx16(coeff_i.g1) * t_w) >>> 15)
                                  + ((sx16(coeff_i.g2) * tt_w) >>> 30);
  wire logic signed [47:0] ofs_w = sx16(coeff_i.ofs0) + ((sx16(coeff_i.ofs1) * t_w) >>> 15);
  wire logic [15:0] cust_d = sat16(((sx16(fact_d) * gain_w) >>> 15) + ofs_w);

  // Updated only by new samples, so register reads never disturb them
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meas_o <= '0;
    end else if (sample_valid_i) begin
      meas_o <= '{temp: temp_d, raw: raw_d, factory: fact_d, customer: cust_d};
    end
  end

endmodule : field_path

/* File: hw/sensor_readout_regs.sv */
/*
  One die's readout registers, setting store with permanent lock, and the
  command exchange over the shared output pin.
  Assumes the pin idles high, the programmer releases it after its frame,
  and an outside pad resolves pin_o / pin_oe_o against the programmer.
*/
`timescale 1ns/1ns
`include "sensor_readout_cfg.svh"

module sensor_readout_regs #(
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter logic DIE_ID = 1'b0,
  parameter logic signed [15:0] TEMP_TRIM = 16'sh0000,
  parameter logic signed [15:0] FACT_GAIN = 16'sh0000,
  parameter logic signed [15:0] FACT_OFS = 16'sh0000
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic analog_en_o,
  input wire logic sample_valid_i,
  input wire logic [`SAMPLE_W-1:0] field_sample_i,
  input wire logic [15:0] temp_sample_i,
  input wire logic lock_nv_i,
  output logic lock_o,
  output sensor_readout_pkg::meas_t meas_o
);
  import sensor_readout_pkg::*;

  function automatic logic nv_writable(input logic [4:0] a);
    nv_writable = (a >= `ADDR_COEF_BASE && a <= `ADDR_SETUP) || a >= `ADDR_SETPT_BASE;
  endfunction : nv_writable

  function automatic logic readable(input logic [4:0] a);
    readable = a <= `ADDR_LOCK || a >= `ADDR_SETPT_BASE;
  endfunction : readable

  // Pin synchroniser; a level counts once the last two stages agree
  logic [2:0] sync_q;
  logic line_q;
  logic line_prev_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_q <= 3'h7;
      line_q <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
      if (sync_q[1] == sync_q[2]) line_q <= sync_q[2];
      line_prev_q <= line_q;
    end
  end

  wire logic fall = line_prev_q & ~line_q;

  // Link state and counters
  link_state_t state_q, state_d;
  logic [15:0] cyc_q, cyc_d;
  logic [4:0] bit_q, bit_d;
  logic [`FRAME_BITS-1:0] rx_q, rx_d;
  logic [`RESP_BITS-1:0] tx_q, tx_d;
  logic oe_q, oe_d;
  logic analog_q, analog_d;
  logic do_exec;

  // Setting store
  logic [15:0] coef_q [0:`NUM_COEFS-1];
  logic [15:0] setpt_q [0:`NUM_SETPTS-1];
  logic [2:0] setup_q;
  logic lock_q;
  logic boot_q;

  wire frame_t frm = rx_q;
  wire logic selected = frm.die == DIE_ID;
  wire logic wr_ok = frm.cmd == CMD_WRITE && nv_writable(frm.addr) && !lock_q;
  wire logic do_write = do_exec && selected && wr_ok;
  wire logic do_lock = do_exec && selected && frm.cmd == CMD_LOCK;
  wire logic bit_done = cyc_q == 16'(BIT_CYCLES - 1);
  wire logic half_bit = cyc_q == 16'(BIT_CYCLES / 2 - 1);
  wire coeff_t coeff = '{ofs0: coef_q[0], ofs1: coef_q[1], g0: coef_q[2], g1: coef_q[3], g2: coef_q[4]};

  // Read map, unmapped words read zero
  logic [15:0] rd_map [0:31];
  assign rd_map[`ADDR_TEMP] = meas_o.temp;
  assign rd_map[`ADDR_RAW] = meas_o.raw;
  assign rd_map[`ADDR_FACTORY] = meas_o.factory;
  assign rd_map[`ADDR_CUSTOMER] = meas_o.customer;
  assign rd_map[`ADDR_SETUP] = {13'h0000, setup_q};
  assign rd_map[`ADDR_LOCK] = {15'h0000, lock_q};
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_COEFS; gi++) begin : g_coef_rd
      assign rd_map[gi + `ADDR_COEF_BASE] = coef_q[gi];
    end
    for (gi = `ADDR_LOCK + 1; gi < `ADDR_SETPT_BASE; gi++) begin : g_hole_rd
      assign rd_map[gi] = 16'h0000;
    end
    for (gi = 0; gi < `NUM_SETPTS; gi++) begin : g_setpt_rd
      assign rd_map[gi + `ADDR_SETPT_BASE] = setpt_q[gi];
    end
  endgenerate

  wire logic [15:0] rd_data = frm.cmd == CMD_READ ? rd_map[frm.addr] : 16'h0000;
  wire logic resp_ok = (frm.cmd == CMD_READ && readable(frm.addr)) || wr_ok || frm.cmd == CMD_LOCK;

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q + 16'h0001;
    bit_d = bit_q;
    rx_d = rx_q;
    tx_d = tx_q;
    oe_d = oe_q;
    analog_d = analog_q;
    do_exec = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cyc_d = 16'h0000;
        oe_d = 1'b0;
        analog_d = 1'b1;
        tx_d = '1;
        if (fall) begin
          state_d = ST_START;
          analog_d = 1'b0;
        end
      end
      ST_START: begin
        // A start shorter than half a bit is a glitch
        if (half_bit) begin
          cyc_d = 16'h0000;
          bit_d = 5'h00;
          state_d = line_q ? ST_IDLE : ST_RX;
          analog_d = line_q;
        end
      end
      ST_RX: begin
        if (bit_done) begin
          cyc_d = 16'h0000;
          rx_d = {rx_q[`FRAME_BITS-2:0], line_q};
          bit_d = bit_q + 5'h01;
          if (bit_q == 5'(`FRAME_BITS - 1)) state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        do_exec = 1'b1;
        cyc_d = 16'h0000;
        bit_d = 5'h00;
        if (selected && frm.cmd != CMD_NOP) begin
          tx_d = {1'b0, rd_data, resp_ok, 1'b1};
          oe_d = 1'b1;
          state_d = ST_TX;
        end else begin
          state_d = ST_GAP;
        end
      end
      ST_TX: begin
        if (bit_done) begin
          cyc_d = 16'h0000;
          tx_d = {tx_q[`RESP_BITS-2:0], 1'b1};
          bit_d = bit_q + 5'h01;
          if (bit_q == 5'(`RESP_BITS - 1)) begin
            state_d = ST_GAP;
            oe_d = 1'b0;
          end
        end
      end
      ST_GAP: begin
        // One released bit time before the analog path returns
        if (bit_done) begin
          state_d = ST_IDLE;
          analog_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      cyc_q <= 16'h0000;
      bit_q <= 5'h00;
      rx_q <= '0;
      tx_q <= '1;
      oe_q <= 1'b0;
      analog_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      analog_q <= analog_d;
    end
  end

  // Lock is taken from the stored copy after reset release and can only be set
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
      if (!boot_q) lock_q <= lock_nv_i | do_lock;
      else if (do_lock) lock_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `NUM_COEFS; i++) coef_q[i] <= `COEF_RESET;
      for (int i = 0; i < `NUM_SETPTS; i++) setpt_q[i] <= `SETPT_RESET;
      setup_q <= `SETUP_RESET;
    end else if (do_write) begin
      if (frm.addr >= `ADDR_SETPT_BASE) setpt_q[frm.addr[3:0]] <= frm.data;
      else if (frm.addr == `ADDR_SETUP) setup_q <= frm.data[2:0];
      else coef_q[3'(frm.addr - `ADDR_COEF_BASE)] <= frm.data;
    end
  end

  field_path #(
    .TEMP_TRIM(TEMP_TRIM),
    .FACT_GAIN(FACT_GAIN),
    .FACT_OFS(FACT_OFS)
  ) u_field_path (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .sample_valid_i(sample_valid_i),
    .field_sample_i(field_sample_i),
    .temp_sample_i(temp_sample_i),
    .barrel_i(setup_q),
    .coeff_i(coeff),
    .meas_o(meas_o)
  );

  assign pin_o = tx_q[`RESP_BITS-1];
  assign pin_oe_o = oe_q;
  assign analog_en_o = analog_q;
  assign lock_o = lock_q;

endmodule : sensor_readout_regs

/* File: tb/prog_station.sv */
/*
  Programming station model: sends one frame on the shared pin, reads the answer.
  Assumes a pull-up on the pin and that the die wins while it drives.
*/
`timescale 1ns/1ns
module prog_station #(
  parameter int BIT = 16
) (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic drv_o
);
  import sensor_readout_pkg::*;
  initial drv_o = 1'b1;
  // Last bit cut short so the die's start bit is never masked
  task automatic xfer(input frame_t f, output logic [18:0] r, output logic ok);
    logic [24:0] s;
    int n;
    s = {1'b0, f};
    ok = 1'b0;
    r = '1;
    for (int i = 24; i >= 0; i--) begin
      drv_o <= s[i];
      repeat (i == 0 ? BIT - 2 : BIT) @(posedge mclk_i);
    end
    drv_o <= 1'b1;
    @(posedge mclk_i);
    for (n = 0; n < 2 * BIT && line_i; n++) @(posedge mclk_i);
    if (!line_i) begin
      ok = 1'b1;
      repeat (BIT / 2) @(posedge mclk_i);
      for (int i = 18; i >= 0; i--) begin
        r[i] = line_i;
        if (i > 0) repeat (BIT) @(posedge mclk_i);
      end
    end
  endtask : xfer
endmodule : prog_station

/* File: tb/sensor_readout_regs_sva.sv */
/*
  Port checker of the readout block: answer framing, analog muting, lock.
  Assumes it is bound to every instance of the block.
*/
`timescale 1ns/1ns
module sensor_readout_regs_sva #(
  parameter int BIT_CYCLES = 100
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic pin_o,
  input wire logic pin_oe_o,
  input wire logic analog_en_o,
  input wire logic sample_valid_i,
  input wire logic lock_nv_i,
  input wire logic lock_o,
  input wire sensor_readout_pkg::meas_t meas_o
);
  import sensor_readout_pkg::*;
  localparam int GAP_LO = BIT_CYCLES - 2;
  localparam int GAP_HI = BIT_CYCLES + 2;
  int oe_cnt_q;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) oe_cnt_q <= 0;
    else oe_cnt_q <= pin_oe_o ? oe_cnt_q + 1 : 0;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  AST_MUTE: assert property (pin_oe_o |-> !analog_en_o) else $error("analog on in answer");
  AST_GAP: assert property ($fell(pin_oe_o) |-> (!analog_en_o && !pin_oe_o) [*8]) else $error("gap busy");
  AST_GAP_END: assert property ($fell(pin_oe_o) |-> ##[GAP_LO:GAP_HI] analog_en_o) else $error("gap end");
  AST_START: assert property ($rose(pin_oe_o) |-> !pin_o) else $error("no start bit");
  AST_STOP: assert property ($fell(pin_oe_o) |-> $past(pin_o)) else $error("no stop bit");
  AST_LEN: assert property ($fell(pin_oe_o) |-> oe_cnt_q == 19 * BIT_CYCLES) else $error("answer length");
  AST_IDLE: assert property (!pin_oe_o |-> pin_o) else $error("pin idle low");
  AST_LOCK_KEEP: assert property (lock_o |=> lock_o) else $error("lock cleared");
  AST_LOCK_LOAD: assert property ($rose(resetn_i) |=> lock_o == $past(lock_nv_i)) else $error("lock load");
  AST_HOLD: assert property (!sample_valid_i |=> $stable(meas_o)) else $error("meas moved");
  cover property ($rose(pin_oe_o));
  cover property ($rose(lock_o));
  cover property ($fell(analog_en_o) ##[1:1000] analog_en_o);
endmodule : sensor_readout_regs_sva
bind sensor_readout_regs sensor_readout_regs_sva #(.BIT_CYCLES(BIT_CYCLES)) sva_u (.mclk_i(mclk_i),
  .resetn_i(resetn_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .analog_en_o(analog_en_o),
  .sample_valid_i(sample_valid_i), .lock_nv_i(lock_nv_i), .lock_o(lock_o), .meas_o(meas_o));

/* File: tb/tb.sv */
/*
  Testbench of the readout block: samples, link reads and writes, lock.
  Assumes a pulled-up pin shared by the die and the station model.
*/
`timescale 1ns/1ns
`include "sensor_readout_cfg.svh"
module tb;
  import sensor_readout_pkg::*;
  localparam int BIT = 16;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [`SAMPLE_W-1:0] field_sample_i = '0;
  logic [15:0] temp_sample_i = '0;
  logic lock_nv_i = 1'b0;
  logic pin_o, pin_oe_o, analog_en_o, lock_o, drv, line;
  meas_t meas_o;
  int fails = 0;
  int compares = 0;
  always #5 mclk_i = ~mclk_i;
  assign line = pin_oe_o ? pin_o : drv;
  sensor_readout_regs #(.BIT_CYCLES(BIT)) dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .pin_i(line),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .analog_en_o(analog_en_o), .sample_valid_i(sample_valid_i),
    .field_sample_i(field_sample_i), .temp_sample_i(temp_sample_i), .lock_nv_i(lock_nv_i),
    .lock_o(lock_o), .meas_o(meas_o));
  prog_station #(.BIT(BIT)) ps_u (.mclk_i(mclk_i), .line_i(line), .drv_o(drv));
  function automatic logic [15:0] sat(input int v);
    return v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : v[15:0];
  endfunction : sat
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("counts compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic op(input cmd_t c, input logic d, input logic [4:0] a, input logic [15:0] v,
                    output logic [15:0] rd, output logic st);
    logic [18:0] r;
    logic ok;
    int n;
    ps_u.xfer('{c, d, a, v}, r, ok);
    rd = r[17:2];
    st = r[1];
    chk({15'h0, ok}, {15'h0, d == 1'b0 && c != CMD_NOP});
    if (ok) chk({14'h0, r[18], r[0]}, 16'h1);
    // Next frame only once the die is idle again
    for (n = 0; n < 40 * BIT && !analog_en_o; n++) @(posedge mclk_i);
    if (!analog_en_o) begin
      chk({15'h0, analog_en_o}, 16'h0001);
      complete_run();
    end
    repeat (4) @(posedge mclk_i);
  endtask : op
  task automatic samp(input logic [21:0] f, input logic [15:0] t);
    field_sample_i <= f;
    temp_sample_i <= t;
    sample_valid_i <= 1'b1;
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask : samp
  initial begin
    logic [15:0] rd, e, t, ex[4];
    logic [21:0] f;
    logic st;
    int sh;
    void'($urandom(59));
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    chk({15'h0, lock_o}, 16'h0);
    for (int k = 0; k < 9; k++) begin
      if (k == 3) op(CMD_WRITE, 1'b0, `ADDR_SETUP, 16'h0003, rd, st);
      if (k == 6) op(CMD_WRITE, 1'b0, `ADDR_COEF_BASE, 16'h0010, rd, st);
      if (k == 3 || k == 6) chk({15'h0, st}, 16'h0001);
      sh = k < 3 ? 6 : 4;
      f = k % 3 == 0 ? 22'h1fffff : k % 3 == 1 ? 22'h200000 : 22'($urandom);
      t = 16'($urandom);
      samp(f, t);
      e = sat($signed(f) >>> sh);
      ex = '{t, e, e, sat($signed(e) + (k < 6 ? 0 : 16))};
      for (int a = 0; a < 4; a++) begin
        chk(meas_o[63-16*a -: 16], ex[a]);
        if (k % 3 == 2) op(CMD_READ, 1'b0, 5'(a), 16'h0, rd, st);
        if (k % 3 == 2) chk(rd, ex[a]);
      end
      $display("test sample %0d done", k);
    end
    t = 16'($urandom);
    op(CMD_WRITE, 1'b0, 5'h1f, t, rd, st);
    op(CMD_READ, 1'b0, 5'h1f, 16'h0, rd, st);
    chk(rd, t);
    // Unmapped word: reads zero with a failed status
    op(CMD_READ, 1'b0, 5'h0b, 16'h0, rd, st);
    chk(rd, 16'h0000);
    chk({15'h0, st}, 16'h0000);
    op(CMD_WRITE, 1'b0, `ADDR_RAW, 16'h1234, rd, st);
    chk({15'h0, st}, 16'h0);
    chk(meas_o.raw, e);
    op(CMD_READ, 1'b1, `ADDR_RAW, 16'h0, rd, st);
    op(CMD_NOP, 1'b0, `ADDR_RAW, 16'h0, rd, st);
    op(CMD_LOCK, 1'b0, 5'h00, 16'h0, rd, st);
    chk({14'h0, st, lock_o}, 16'h3);
    op(CMD_WRITE, 1'b0, `ADDR_SETUP, 16'h0005, rd, st);
    chk({15'h0, st}, 16'h0);
    op(CMD_READ, 1'b0, `ADDR_SETUP, 16'h0, rd, st);
    chk(rd, 16'h0003);
    op(CMD_WRITE, 1'b0, 5'h1f, ~t, rd, st);
    op(CMD_READ, 1'b0, 5'h1f, 16'h0, rd, st);
    chk(rd, t);
    op(CMD_READ, 1'b0, `ADDR_LOCK, 16'h0, rd, st);
    chk(rd, 16'h0001);
    lock_nv_i <= 1'b1;
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk({15'h0, lock_o}, 16'h1);
    $display("test link and lock done");
    complete_run();
  end
endmodule : tb
